// [core/device_reset_control_defs.vh]
// Purpose: constants of the device reset controller
// Assumes: 100 MHz system clock
// Notes:   byte offsets on the register bus; counts derive from times
`ifndef DEVICE_RESET_CONTROL_DEFS_VH
`define DEVICE_RESET_CONTROL_DEFS_VH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS    10
`define CLK_FREQ_KHZ     100000
`define POWER_UP_TIMER_TIME_MS     64
`define POWER_UP_TIMER_CYCLES      (`POWER_UP_TIMER_TIME_MS * `CLK_FREQ_KHZ)
`define START_DELAY_CYC  10
`define BOR_FILT_NS      1000
`define BOR_FILT_CYC     ((`BOR_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXT_FILT_NS      200
`define EXT_FILT_CYC     ((`EXT_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ---------------------------------------------------------------
// register offsets and fields
// ---------------------------------------------------------------
`define OFS_CTRL         4'h0
`define OFS_STATUS       4'h4
`define OFS_CAUSE        4'h8
`define CTRL_SWBOR       0
`define CTRL_PULLUP      1
`define CTRL_RST         2'h0
`define STAT_RDY         0
`define STAT_BORACT      1
`define STAT_EXTEN       2
`define STAT_RUN         3
`define STAT_ST_LSB      4
`define CAUSE_POR        0
`define CAUSE_BOR        1
`define CAUSE_EXT        2
`define CAUSE_RST        3'h6

// ---------------------------------------------------------------
// configuration encodings
// ---------------------------------------------------------------
`define MODE_ON          2'h3
`define MODE_NOSLEEP     2'h2
`define MODE_SW          2'h1
`define MODE_OFF         2'h0
`define POWER_UP_TIMER_DISABLED    2'h3
`define SYNC_RST         5'h11

`endif

// [core/reset_sync2.v]
// Purpose: two flip-flop synchroniser for a group of levels
// Assumes: inputs are independent levels
// Notes:   first stage feeds only the second stage
`default_nettype none

module reset_sync2 #(
  parameter             WIDTH   = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk,     // system clock
  input  wire             reset_n, // sync reset, active low
  input  wire [WIDTH-1:0] asyncIn, // levels from outside
  output reg  [WIDTH-1:0] syncOut  // synchronised levels
);

  reg [WIDTH-1:0] meta_r;

  // two stage capture
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      meta_r  <= RST_VAL;
      syncOut <= RST_VAL;
    end
    else
    begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule // reset_sync2

`default_nettype wire

// [core/level_filter.v]
// Purpose: reject pulses shorter than LEN cycles on a level
// Assumes: input already synchronised
// Notes:   output follows only after LEN equal samples
`default_nettype none

module level_filter #(
  parameter       LEN     = 20,
  parameter       CW      = 8,
  parameter [0:0] RST_VAL = 1'b0
) (
  input  wire clk,     // system clock
  input  wire reset_n, // sync reset, active low
  input  wire levelIn, // raw synchronised level
  output reg  levelOut // filtered level
);

  localparam integer LAST_I = LEN - 1;
  wire [31:0]   lastW = LAST_I;
  reg  [CW-1:0] cnt_r;

  // count cycles of disagreement, restart on agreement
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      cnt_r    <= {CW{1'b0}};
      levelOut <= RST_VAL;
    end
    else if (levelIn == levelOut)
      cnt_r <= {CW{1'b0}};
    else if (cnt_r == lastW[CW-1:0])
    begin
      cnt_r    <= {CW{1'b0}};
      levelOut <= levelIn;
    end
    else
      cnt_r <= cnt_r + 1'b1;
  end

endmodule // level_filter

`default_nettype wire

// [core/device_reset_control.v]
// Purpose: device reset generation and qualification
// Assumes: detectors asynchronous, fuses static, sleepActive on clk
// Notes:   registers on an Avalon-MM slave with one wait state
// Operation
// - brownout mode 11 always on, 10 off in sleep, 01 software, 00 off
// - brownout trip longer than the filter resets and clears its flag
// - mode 11 holds start-up until ready; protection stays in sleep
// - mode 11 never delays wake-up from sleep
// - mode 10 drops protection in sleep, wake waits for ready
// - mode 01 follows software enable; sleep leaves it unchanged
// - mode 01 enable clear or mode 00 start without waiting ready
// - mode 01 enable set waits for ready after release or wake
// - ready status readable; protection acts once ready
// - mode 00 ignores the software enable for brownout behaviour
// - low-power brownout trip holds reset and clears brownout flag
// - low-power and main brownout requests are ORed together
// - low-power brownout enabled only by its fuse bit
// - mode 10 low-power trip holds reset and re-arms power-on reset
// - pin enabled if programming bit 1, else by pin enable bit
// - enabled pin held low keeps reset and clears external flag
// - short low pulses on the pin are filtered out
// - internal resets never drive the reset pin low
// - disabled pin is a plain input with software pull-up
// - power-on level holds reset; optional timer extends it
// - power-up timer holds reset 64 ms after release
// - execution starts after a ten-cycle start delay once the synchronised pin release has passed the filter
`include "device_reset_control_defs.vh"
`default_nettype none

module device_reset_control #(
  parameter POWER_UP_TIMER_CYCLES = `POWER_UP_TIMER_CYCLES,
  parameter BOR_FILT    = `BOR_FILT_CYC,
  parameter EXT_FILT    = `EXT_FILT_CYC
) (
  input  wire        clk,            // system clock
  input  wire        reset_n,        // sync reset, active low
  input  wire [3:0]  address,        // byte address
  input  wire        read,           // read request
  input  wire        write,          // write request
  input  wire [31:0] writedata,      // write data
  input  wire [3:0]  byteenable,     // byte lanes
  output reg  [31:0] readdata,       // read data
  output reg         waitrequest,    // stall
  input  wire [1:0]  brownoutModeSel,   // fuse mode field
  input  wire        lowPowerBorEnable, // fuse lp brownout
  input  wire [1:0]  powerUpTimerSel,   // fuse, 11 = off
  input  wire        extResetPinEnable, // fuse pin enable
  input  wire        lowVoltProgEnable, // fuse prog bit
  input  wire        sleepActive,    // core in sleep
  input  wire        porLow,         // supply below por level
  input  wire        borTrip,        // brownout detector
  input  wire        borReady,       // brownout circuit ready
  input  wire        lpborTrip,      // low-power detector
  input  wire        extPinIn,       // reset pin level
  output reg         extPinOut,      // reset pin drive value
  output reg         extPinOe,       // reset pin drive enable
  output reg         extPinPullup,   // weak pull-up enable
  output reg         borEnable,      // brownout circuit on
  output reg         lpborEnable,    // low-power circuit on
  output reg         porRearm,       // re-arm power-on reset
  output reg         deviceReset,    // device held in reset
  output reg         runEnable       // execution allowed
);

  // ---------------------------------------------------------------
  // states and constants
  // ---------------------------------------------------------------
  localparam [2:0] ST_HOLD  = 3'h0;
  localparam [2:0] ST_POWER_UP_TIMER  = 3'h1;
  localparam [2:0] ST_WAIT  = 3'h2;
  localparam [2:0] ST_START = 3'h3;
  localparam [2:0] ST_RUN   = 3'h4;
  localparam [2:0] ST_WAKE  = 3'h5;

  localparam integer POWER_UP_TIMER_LAST_I  = POWER_UP_TIMER_CYCLES - 1;
  localparam integer START_LAST_I = `START_DELAY_CYC - 1;
  wire [31:0] pwrtLastW  = POWER_UP_TIMER_LAST_I;
  wire [31:0] startLastW = START_LAST_I;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  wire [4:0]  syncV;
  wire        porS;
  wire        borS;
  wire        rdyS;
  wire        lpS;
  wire        pinS;
  wire        borFilt;
  wire        pinFilt;
  reg  [1:0]  ctrl_r;
  reg  [2:0]  cause_r;
  reg  [2:0]  cause_nxt;
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [22:0] pwrtCnt_r;
  reg  [3:0]  startCnt_r;
  reg         sleepPrev_r;
  reg         borActive;
  reg         needReady;
  reg         wakeWait;
  wire        extEn;
  wire        borReq;
  wire        lpReq;
  wire        brownReq;
  wire        hardReq;
  wire        extReq;
  wire        pwrtOn;
  wire        waking;
  wire        busWr;
  wire        busRd;
  reg  [31:0] rdMux;

  // ---------------------------------------------------------------
  // synchronisers and filters
  // ---------------------------------------------------------------
  // detectors sync
  reset_sync2 #(
    .WIDTH   (5),
    .RST_VAL (`SYNC_RST)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn ({extPinIn, lpborTrip, borReady, borTrip, porLow}),
    .syncOut (syncV)
  );

  assign porS = syncV[0];
  assign borS = syncV[1];
  assign rdyS = syncV[2];
  assign lpS  = syncV[3];
  assign pinS = syncV[4];

  level_filter #(
    .LEN     (BOR_FILT),
    .CW      (12),
    .RST_VAL (1'b0)
  ) u_borFilt (
    .clk      (clk),
    .reset_n  (reset_n),
    .levelIn  (borS),
    .levelOut (borFilt)
  );

  level_filter #(
    .LEN     (EXT_FILT),
    .CW      (12),
    .RST_VAL (1'b1)
  ) u_pinFilt (
    .clk      (clk),
    .reset_n  (reset_n),
    .levelIn  (pinS),
    .levelOut (pinFilt)
  );

  // ---------------------------------------------------------------
  // brownout mode decode
  // ---------------------------------------------------------------
  // mode selects protection and ready wait
  always @*
  begin
    borActive = 1'b0;
    needReady = 1'b0;
    wakeWait  = 1'b0;
    case (brownoutModeSel)
      `MODE_ON:
      begin
        borActive = 1'b1;
        needReady = 1'b1;
        wakeWait  = 1'b0;
      end
      // off in sleep, wake waits ready
      `MODE_NOSLEEP:
      begin
        borActive = !sleepActive;
        needReady = 1'b1;
        wakeWait  = 1'b1;
      end
      `MODE_SW:
      begin
        borActive = ctrl_r[`CTRL_SWBOR];
        needReady = ctrl_r[`CTRL_SWBOR];
        wakeWait  = ctrl_r[`CTRL_SWBOR];
      end
      `MODE_OFF:
      begin
        borActive = 1'b0;
        needReady = 1'b0;
        wakeWait  = 1'b0;
      end
      default:
      begin
        borActive = 1'b0;
        needReady = 1'b0;
        wakeWait  = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // reset requests
  // ---------------------------------------------------------------
  // protection only once ready
  assign borReq   = borActive & rdyS & borFilt;
  assign lpReq    = lowPowerBorEnable & lpS;
  assign brownReq = borReq | lpReq;
  assign hardReq  = porS | brownReq;
  assign extEn    = lowVoltProgEnable | extResetPinEnable;
  assign extReq   = extEn & !pinFilt;
  assign pwrtOn   = (powerUpTimerSel != `POWER_UP_TIMER_DISABLED);
  assign waking   = sleepPrev_r & !sleepActive;

  // ---------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_HOLD:
        if (!hardReq)
          state_nxt = pwrtOn ? ST_POWER_UP_TIMER : ST_WAIT;
      ST_POWER_UP_TIMER:
        if (hardReq)
          state_nxt = ST_HOLD;
        else if (pwrtCnt_r == pwrtLastW[22:0])
          state_nxt = ST_WAIT;
      ST_WAIT:
        if (hardReq)
          state_nxt = ST_HOLD;
        else if (!extReq && (rdyS || !needReady))
          state_nxt = ST_START;
      ST_START:
        if (hardReq)
          state_nxt = ST_HOLD;
        else if (extReq)
          state_nxt = ST_WAIT;
        else if (startCnt_r == startLastW[3:0])
          state_nxt = ST_RUN;
      ST_RUN:
        if (hardReq)
          state_nxt = ST_HOLD;
        else if (extReq)
          state_nxt = ST_WAIT;
        else if (waking && wakeWait && !rdyS)
          state_nxt = ST_WAKE;
      ST_WAKE:
        if (hardReq)
          state_nxt = ST_HOLD;
        else if (extReq)
          state_nxt = ST_WAIT;
        else if (rdyS || !wakeWait)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_HOLD;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer registers and counters
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_r     <= ST_HOLD;
      pwrtCnt_r   <= 23'h000000;
      startCnt_r  <= 4'h0;
      sleepPrev_r <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      sleepPrev_r <= sleepActive;
      if (state_r == ST_POWER_UP_TIMER)
        pwrtCnt_r <= pwrtCnt_r + 23'h000001;
      else
        pwrtCnt_r <= 23'h000000;
      if (state_r == ST_START)
        startCnt_r <= startCnt_r + 4'h1;
      else
        startCnt_r <= 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // outputs toward the device
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      deviceReset  <= 1'b1;
      runEnable    <= 1'b0;
      borEnable    <= 1'b0;
      lpborEnable  <= 1'b0;
      porRearm     <= 1'b0;
      extPinPullup <= 1'b1;
      extPinOut    <= 1'b0;
      extPinOe     <= 1'b0;
    end
    else
    begin
      deviceReset <= (state_nxt != ST_RUN) && (state_nxt != ST_WAKE);
      runEnable   <= (state_nxt == ST_RUN);
      borEnable   <= borActive;
      lpborEnable <= lowPowerBorEnable;
      // lp trip in mode 10 re-arms por
      porRearm    <= lpReq && (brownoutModeSel == `MODE_NOSLEEP);
      extPinPullup <= extEn | ctrl_r[`CTRL_PULLUP];
      extPinOut   <= 1'b0;
      extPinOe    <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------
  // one wait state: waitrequest drops the cycle after a request
  assign busWr = write & !waitrequest;
  assign busRd = read & waitrequest;

  always @*
  begin
    rdMux = 32'h00000000;
    case (address)
      `OFS_CTRL:
        rdMux[1:0] = ctrl_r;
      `OFS_STATUS:
      begin
        rdMux[`STAT_RDY]    = rdyS;
        rdMux[`STAT_BORACT] = borActive;
        rdMux[`STAT_EXTEN]  = extEn;
        rdMux[`STAT_RUN]    = runEnable;
        rdMux[`STAT_ST_LSB+2:`STAT_ST_LSB] = state_r;
      end
      `OFS_CAUSE:
        rdMux[2:0] = cause_r;
      default:
        rdMux = 32'h00000000;
    endcase
  end

  // cause flags: hardware clear wins over a software write
  always @*
  begin
    cause_nxt = cause_r;
    if (busWr && address == `OFS_CAUSE && byteenable[0])
      cause_nxt = writedata[2:0];
    if (porS)
    begin
      cause_nxt[`CAUSE_POR] = 1'b0;
      cause_nxt[`CAUSE_EXT] = 1'b1;
    end
    if (brownReq)
    begin
      cause_nxt[`CAUSE_BOR] = 1'b0;
      cause_nxt[`CAUSE_EXT] = 1'b1;
    end
    if (extReq)
      cause_nxt[`CAUSE_EXT] = 1'b0;
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
      ctrl_r      <= `CTRL_RST;
      cause_r     <= `CAUSE_RST;
    end
    else
    begin
      waitrequest <= !((read | write) & waitrequest);
      cause_r     <= cause_nxt;
      if (busRd)
        readdata <= rdMux;
      if (busWr && address == `OFS_CTRL && byteenable[0])
        ctrl_r <= writedata[1:0];
    end
  end

endmodule // device_reset_control

`default_nettype wire

// [test/supply_pin_model.sv]
// Purpose: supply detectors and reset pin beside the controller
// Assumes: bench sets supply and button levels
// Notes:   ready 8 cycles after power-up; a bare pin toggles
`default_nettype none
module supply_pin_model (
  input  wire logic clk,          // system clock
  input  wire logic supplyLow,    // under power-on level
  input  wire logic brownDip,     // under brownout level
  input  wire logic lpDip,        // under low-power level
  input  wire logic pinPress,     // button pulls pin low
  input  wire logic borEnable,    // detector powered
  input  wire logic extPinOut,    // device drive value
  input  wire logic extPinOe,     // device drive enable
  input  wire logic extPinPullup, // weak pull-up
  output logic      porLow,       // power-on detector
  output logic      borTrip,      // brownout detector
  output logic      borReady,     // brownout circuit ready
  output logic      lpborTrip,    // low-power detector
  output logic      extPinIn      // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] readyCnt_r = 4'h0;
  logic       float_r = 1'h0;
  // ---------------------------------------------------------------
  // detectors and pin
  // ---------------------------------------------------------------
  // ready rises 8 cycles after power-up, drops when unpowered
  always @(posedge clk)
  begin
    if (!borEnable)
      readyCnt_r <= 4'h0;
    else if (readyCnt_r != 4'h8)
      readyCnt_r <= readyCnt_r + 4'h1;
    float_r <= !float_r;
  end
  assign borReady  = readyCnt_r == 4'h8;
  assign porLow    = supplyLow;
  assign borTrip   = brownDip && borEnable; // off detector reads quiet
  assign lpborTrip = lpDip;
  // pin: drive, else button, else pull-up, else floating
  assign extPinIn  = extPinOe ? extPinOut : pinPress ? 1'h0 :
                     extPinPullup ? 1'h1 : float_r;
endmodule // supply_pin_model
`default_nettype wire

// [test/device_reset_control_monitor.sv]
// Purpose: port checker of the device reset controller
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to device_reset_control by the bind below
`default_nettype none
module device_reset_control_monitor (
  input wire logic       clk,               // system clock
  input wire logic       reset_n,           // sync reset
  input wire logic       read,              // bus read
  input wire logic       write,             // bus write
  input wire logic       waitrequest,       // bus stall
  input wire logic [1:0] brownoutModeSel,   // mode fuse
  input wire logic       lowPowerBorEnable, // lp fuse
  input wire logic       porLow,            // power-on level
  input wire logic       lpborTrip,         // lp detector
  input wire logic       extPinOe,          // pin drive enable
  input wire logic       borEnable,         // protection on
  input wire logic       lpborEnable,       // lp circuit on
  input wire logic       porRearm,          // re-arm request
  input wire logic       deviceReset,       // device in reset
  input wire logic       runEnable          // execution allowed
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_pin_undriven: assert property (!extPinOe)
    else $error("reset pin driven by device");
  a_bus_one_wait: assert property ((read || write) && waitrequest
    |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one wait state");
  a_por_hold: assert property (porLow ##1 porLow |-> ##[0:3] deviceReset)
    else $error("low supply without reset");
  a_run_excl: assert property (runEnable |-> !deviceReset)
    else $error("running while in reset");
  a_lp_reset: assert property ((lpborTrip && lowPowerBorEnable) [*3]
    |-> ##[0:3] deviceReset)
    else $error("low-power trip without reset");
  a_rearm_mode: assert property (porRearm |-> brownoutModeSel == 2'h2)
    else $error("re-arm outside mode 10");
  a_lp_mirror: assert property ($past(reset_n)
    |-> lpborEnable == $past(lowPowerBorEnable))
    else $error("low-power enable not from fuse");
  a_off_no_prot: assert property (brownoutModeSel == 2'h0 |-> !borEnable)
    else $error("protection on in mode 00");
  a_on_prot: assert property ($past(reset_n) && brownoutModeSel == 2'h3
    |-> borEnable)
    else $error("protection off in mode 11");
  c_reset: cover property ($rose(deviceReset));
  c_wake_wait: cover property ($fell(runEnable) && !deviceReset);
  c_rearm: cover property ($rose(porRearm));
endmodule // device_reset_control_monitor
bind device_reset_control device_reset_control_monitor mon (.clk, .reset_n,
  .read, .write, .waitrequest, .brownoutModeSel, .lowPowerBorEnable, .porLow,
  .lpborTrip, .extPinOe, .borEnable, .lpborEnable, .porRearm, .deviceReset,
  .runEnable);
`default_nettype wire

// [test/device_reset_control_tb_top.sv]
// Purpose: self-checking bench of the device reset controller
// Assumes: detector and pin model beside the design
// Notes:   short timer and filter counts keep the run brief
`include "device_reset_control_defs.vh"
`default_nettype none
module device_reset_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POWER_UP_TIMER = 50;
  logic        clk, reset_n, read, write, sleepActive, waitrequest;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, q, d;
  logic [1:0]  brownoutModeSel, powerUpTimerSel;
  logic        lowPowerBorEnable, extResetPinEnable, lowVoltProgEnable;
  logic        porLow, borTrip, borReady, lpborTrip, extPinIn, extPinOut;
  logic        extPinOe, extPinPullup, borEnable, lpborEnable, porRearm;
  logic        deviceReset, runEnable, supplyLow, brownDip, lpDip, pinPress;
  logic        en;
  int          fail_count, check_count, seed, n, causeRef;
  // ---------------------------------------------------------------
  // design, far side, clock
  // ---------------------------------------------------------------
  device_reset_control #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER), .BOR_FILT(4), .EXT_FILT(4))
  uut (.clk, .reset_n, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .brownoutModeSel, .lowPowerBorEnable,
    .powerUpTimerSel, .extResetPinEnable, .lowVoltProgEnable, .sleepActive,
    .porLow, .borTrip, .borReady, .lpborTrip, .extPinIn, .extPinOut,
    .extPinOe, .extPinPullup, .borEnable, .lpborEnable, .porRearm,
    .deviceReset, .runEnable);
  supply_pin_model far (.clk, .supplyLow, .brownDip, .lpDip, .pinPress,
    .borEnable, .extPinOut, .extPinOe, .extPinPullup, .porLow, .borTrip,
    .borReady, .lpborTrip, .extPinIn);
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, s);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, s);
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic rd, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rq);
    int k;
    k = 0;
    read      <= rd;
    write     <= !rd;
    address   <= a;
    writedata <= wd;
    @(posedge clk);
    // only the watchdog ends a wait; the slave answers after one wait state
    while (waitrequest !== 1'h0)
    begin
      @(posedge clk);
      k++;
    end
    rq = readdata;
    chk("bus wait", 1, k);
    read  <= 1'h0;
    write <= 1'h0;
    @(posedge clk);
  endtask
  task automatic waitRun();
    n = 0;
    while (runEnable !== 1'h1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    // a release that never comes counts as a mismatch
    chk("run", 1, runEnable);
  endtask
  // reset with fuses set, supply rising 20 cycles after release
  task automatic boot(input logic [1:0] m, pt, input logic ep, lv, lp);
    reset_n           <= 1'h0;
    supplyLow         <= 1'h1;
    brownoutModeSel   <= m;
    powerUpTimerSel   <= pt;
    extResetPinEnable <= ep;
    lowVoltProgEnable <= lv;
    lowPowerBorEnable <= lp;
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    repeat (20) @(posedge clk);
    chk("por hold", 1, deviceReset);
    supplyLow <= 1'h0;
    waitRun();
    chk("timer", pt != 2'h3, n >= POWER_UP_TIMER + 10 && n < 3000);
    causeRef = 6;
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    seed = 32'h56C4;
    fail_count = 0;
    check_count = 0;
    {reset_n, read, write, sleepActive, brownDip, lpDip, pinPress} = '0;
    {address, writedata, powerUpTimerSel, lowVoltProgEnable} = '0;
    {brownoutModeSel, lowPowerBorEnable, extResetPinEnable} = '1;
    byteenable = 4'hF;
    supplyLow = 1'h1;
    boot(2'h3, 2'h0, 1'h1, 1'h0, 1'h1);
    bus(1'h1, `OFS_CTRL, 32'h0, q);
    chk("ctrl reset", 32'h0, q);
    bus(1'h1, 4'hC, 32'h0, q);
    chk("unmapped", 32'h0, q);
    d = $random(seed);
    bus(1'h0, `OFS_CTRL, d, q);
    byteenable <= 4'h0;
    bus(1'h0, `OFS_CTRL, ~d, q);
    byteenable <= 4'hF;
    bus(1'h1, `OFS_CTRL, 32'h0, q);
    chk("ctrl write", d & 32'h3, q);
    // protection, wake and brownout per mode, software enable set
    for (int m = 0; m < 4; m++)
    begin
      boot(2'(m), 2'h1, 1'h1, 1'h0, 1'h1);
      bus(1'h0, `OFS_CTRL, 32'h1, q);
      repeat (16) @(posedge clk);
      chk("awake prot", m != 0, borEnable);
      bus(1'h1, `OFS_STATUS, 32'h0, q);
      chk("ready bit", m != 0, q[0]);
      sleepActive <= 1'h1;
      repeat (20) @(posedge clk);
      chk("sleep prot", m[0], borEnable);
      sleepActive <= 1'h0;
      repeat (4) @(posedge clk);
      chk("wake run", m != 2, runEnable);
      waitRun();
      repeat (16) @(posedge clk);
      brownDip <= 1'h1;
      repeat (12) @(posedge clk);
      brownDip <= 1'h0;
      chk("bor reset", m != 0, deviceReset);
      chk("pin drive", 0, {extPinOe, extPinOut});
      causeRef = m != 0 ? causeRef & 5 : causeRef;
      waitRun();
      repeat (16) @(posedge clk);
      lpDip <= 1'h1;
      repeat (12) @(posedge clk);
      chk("lp reset", 1, deviceReset);
      chk("rearm", m == 2, porRearm);
      lpDip <= 1'h0;
      causeRef = causeRef & 5;
      waitRun();
      bus(1'h1, `OFS_CAUSE, 32'h0, q);
      chk("cause", causeRef, q);
    end
    // pin enable table, filter and start delay
    for (int k = 0; k < 4; k++)
    begin
      en = k != 0;
      boot(2'h3, 2'(k), k[0], k[1], 1'h0);
      lpDip <= 1'h1;
      repeat (12) @(posedge clk);
      lpDip <= 1'h0;
      chk("lp off", 0, deviceReset | lpborEnable);
      bus(1'h1, `OFS_STATUS, 32'h0, q);
      chk("pin on", en, q[2]);
      chk("pull-up", en, extPinPullup);
      pinPress <= 1'h1;
      repeat (2) @(posedge clk);
      pinPress <= 1'h0;
      repeat (8) @(posedge clk);
      chk("short pulse", 0, deviceReset);
      pinPress <= 1'h1;
      repeat (20) @(posedge clk);
      chk("pin reset", en, deviceReset);
      pinPress <= 1'h0;
      waitRun();
      chk("start delay", en, n >= 10 && n < POWER_UP_TIMER);
      causeRef = en ? causeRef & 3 : causeRef;
      bus(1'h1, `OFS_CAUSE, 32'h0, q);
      chk("pin flag", causeRef, q);
      bus(1'h0, `OFS_CTRL, 32'h2, q);
      // pull-up output follows the control bit one edge after the write
      @(posedge clk);
      chk("soft pull-up", 1, extPinPullup);
    end
    wrap_up();
  end
  initial
  begin
    #300000;
    fail_count++;
    wrap_up();
  end
endmodule // device_reset_control_tb_top
`default_nettype wire
